/* dv/cscr_host_model.sv */
// Host model issuing single-byte register reads and writes.
// Assumes read data is updated at the edge that takes the read.
`timescale 1ns/1ps
module cscr_host_model (
    input  wire logic        ref_clk,
    output logic      [11:0] reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [7:0]  reg_rdata
);
    initial begin
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Released address and data lines flip so stale values are never trusted.
    task automatic drop();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask : drop
    task automatic wr(input logic [11:0] a, input logic [7:0] d,
                      input logic [7:0] m);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = d & m;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        drop();
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        d = reg_rdata;
        drop();
    endtask : rd
endmodule : cscr_host_model

/* dv/cscr_regs_assertions.sv */
// Checker for the register bank, bound to every cscr_regs instance.
// Assumes one clock ref_clk and the async active-low reset rst_n.
`timescale 1ns/1ps
module cscr_regs_assertions #(
    parameter int SILENCE_CYCLES = 8
) (
    input wire logic                ref_clk,
    input wire logic                rst_n,
    input wire logic                startup_done,
    input wire logic [11:0]         reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    input wire logic [3:0]          mode_request,
    input wire logic [3:0]          mode_actual,
    input wire cscr_pkg::cscr_mon_t mon,
    input wire logic                bus_rx_dominant,
    input wire cscr_pkg::cscr_cfg_t cfg
);
    // ========
    // Helpers.
    logic        rd71;
    logic        rd72;
    logic [15:0] quiet_q;
    logic [15:0] quiet_d;
    assign rd71 = reg_rd && reg_addr == cscr_pkg::ADDR_SYS_STAT;
    assign rd72 = reg_rd && reg_addr == cscr_pkg::ADDR_CAN_STAT;
    always_comb begin
        quiet_d = bus_rx_dominant ? 16'h0000 : quiet_q + 16'h0001;
        if (quiet_q == 16'hffff) quiet_d = quiet_q;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) quiet_q <= 16'h0000;
        else quiet_q <= quiet_d;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ========
    // Properties.
    sequence s_dom2;
        bus_rx_dominant [*2] ##1 rd72;
    endsequence
    property p_ot;
        rd71 |=> reg_rdata[5] == $past(mon.overtemp && mode_request == 4'hf
            && (mode_actual == 4'hf || mode_actual == 4'h8));
    endproperty
    a_ot: assert property (p_ot) else $error("overtemp bit wrong");
    property p_uv;
        rd71 |=> reg_rdata[3] == $past(mon.supply_uv);
    endproperty
    a_uv: assert property (p_uv) else $error("undervolt bit wrong");
    property p_rsv;
        rd71 || rd72 |=> (reg_rdata & ($past(rd71) ? 8'hc0 : 8'h70)) == 8'h00;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_cts;
        rd72 |=> reg_rdata[7] == $past(mon.can_active && mon.tx_ready);
    endproperty
    a_cts: assert property (p_cts) else $error("ready bit wrong");
    property p_stuck;
        rd72 |=> reg_rdata[2:0] ==
            $past({mon.bus_stuck, mon.tx2_stuck, mon.tx1_stuck});
    endproperty
    a_stuck: assert property (p_stuck) else $error("stuck");
    property p_start;
        startup_done |=> cfg == 5'h00;
    endproperty
    a_start: assert property (p_start) else $error("cfg not cleared");
    property p_ccfg;
        reg_wr && reg_addr == cscr_pkg::ADDR_CAN_CFG && !startup_done |=>
            {cfg.low_power_listen_en, cfg.wake_pattern_select}
            == $past(reg_wdata[1:0]);
    endproperty
    a_ccfg: assert property (p_ccfg) else $error("can cfg out");
    property p_scfg;
        reg_wr && reg_addr == cscr_pkg::ADDR_SYS_CFG && !startup_done |=>
            cfg.shared_supply_select == $past(reg_wdata[0]);
    endproperty
    a_scfg: assert property (p_scfg) else $error("supply cfg out");
    property p_sil_set;
        rd72 && int'(quiet_q) > SILENCE_CYCLES + 2 |=> reg_rdata[3];
    endproperty
    a_sil_set: assert property (p_sil_set) else $error("no silence");
    property p_sil_clr;
        s_dom2 |=> !reg_rdata[3];
    endproperty
    a_sil_clr: assert property (p_sil_clr) else $error("silence stays");
endmodule : cscr_regs_assertions

bind cscr_regs cscr_regs_assertions #(.SILENCE_CYCLES(SILENCE_CYCLES))
    cscr_regs_assertions_i (.ref_clk, .rst_n, .startup_done, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mode_request, .mode_actual,
    .mon, .bus_rx_dominant, .cfg);

/* dv/cscr_regs_tb.sv */
// Self-checking bench for the register bank against a bench model.
// Assumes the host model owns the register port.
`timescale 1ns/1ps
module cscr_regs_tb;
    localparam int SIL = 8;
    logic                ref_clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                startup_done = 1'b0;
    logic                second_pair_cfg = 1'b0;
    logic                txd_in = 1'b1;
    logic                second_tx_input = 1'b1;
    logic                bus_rx_dominant = 1'b1;
    logic [11:0]         reg_addr;
    logic [7:0]          reg_wdata, reg_rdata, rv;
    logic                reg_wr, reg_rd, bus_tx_dominant;
    logic                rxd_out, second_rx_output;
    logic [3:0]          mode_request = 4'h6;
    logic [3:0]          mode_actual = 4'h6;
    cscr_pkg::cscr_mon_t mon = 10'h000;
    cscr_pkg::cscr_irq_t irq = 3'h0;
    cscr_pkg::cscr_cfg_t cfg;
    int                  n_fail = 0, n_tests = 0, seen, direct_normal_entry_flag, prv;
    logic [7:0]          sr = 8'h17;
    logic [3:0]          modes [4] = '{4'h1, 4'h6, 4'h8, 4'hf};
    always #20 ref_clk = ~ref_clk;
    cscr_regs #(.SILENCE_CYCLES(SIL)) cscr_regs_i (.ref_clk, .rst_n,
        .startup_done, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .mode_request, .mode_actual, .mon, .irq, .second_pair_cfg, .txd_in,
        .second_tx_input, .bus_rx_dominant, .bus_tx_dominant, .rxd_out,
        .second_rx_output, .cfg);
    cscr_host_model cscr_host_model_i (.ref_clk, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata);
    // ========
    // Model of the Normal-entry history.
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen = 0;
            direct_normal_entry_flag = 0;
            prv = 0;
        end else begin
            if (seen == 0 && mode_actual == 4'hf) begin
                seen = 1;
                direct_normal_entry_flag = prv;
            end
            prv = mon.in_reset_mode;
        end
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic rc(input logic [11:0] a, input logic [7:0] e);
        logic [7:0] g;
        cscr_host_model_i.rd(a, g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: addr %h read %h want %h",
                     $time, a, g, e);
        end
    endtask : rc
    task automatic cp(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch at %0t: pin %b want %b", $time, g, e);
        end
    endtask : cp
    task automatic do_reset();
        rst_n = 1'b0;
        step(6);
        rst_n = 1'b1;
    endtask : do_reset
    task automatic final_report();
        $display("counts: tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (50000) @(posedge ref_clk);
        n_fail++;
        final_report();
    end
    initial begin
        do_reset();
        rc(12'h041, 8'h00);
        rc(12'h046, 8'h00);
        rc(12'h071, 8'h04);
        rc(12'h123, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            sr = lfsr(sr);
            cscr_host_model_i.wr(12'h041, sr, 8'h33);
            rc(12'h041, sr & 8'h33);
            cp(cfg.low_power_listen_en, sr[1]);
            cp(cfg.wake_pattern_select, sr[0]);
            cscr_host_model_i.wr(12'h046, sr, 8'h1d);
            rc(12'h046, sr & 8'h1d);
            cp(cfg.shared_supply_select, sr[0]);
            cp(cfg.sleep_disable, sr[4]);
            cp(cfg.clamp_disable, sr[3]);
        end
        startup_done = 1'b1;
        step(1);
        startup_done = 1'b0;
        rc(12'h041, 8'h00);
        rc(12'h046, 8'h00);
        $display("test config done");
        for (int i = 0; i < 12; i++) begin
            sr = lfsr(sr);
            mode_request = modes[sr[1:0]];
            mode_actual = modes[sr[3:2]];
            mon = {sr[7:6], lfsr(sr)};
            cscr_host_model_i.wr(12'h071, sr, 8'hff);
            cscr_host_model_i.wr(12'h072, sr, 8'hff);
            rv = {2'h0, mon.overtemp && mode_request == 4'hf &&
                  (mode_actual == 4'hf || mode_actual == 4'h8),
                  mon.dev_mode, mon.supply_uv, seen == 0, direct_normal_entry_flag[0],
                  mon.wake_pin};
            rc(12'h071, rv);
            rv = {mon.can_active & mon.tx_ready, 4'h0, mon.bus_stuck,
                  mon.tx2_stuck, mon.tx1_stuck};
            rc(12'h072, rv);
        end
        mode_actual = 4'h6;
        mon = 10'h020;
        do_reset();
        rc(12'h071, 8'h04);
        mode_actual = 4'hf;
        rc(12'h071, 8'h02);
        $display("test status done");
        bus_rx_dominant = 1'b0;
        step(SIL + 4);
        rc(12'h072, 8'h08);
        bus_rx_dominant = 1'b1;
        step(2);
        rc(12'h072, 8'h00);
        $display("test silence done");
        mon = 10'h010;
        second_pair_cfg = 1'b1;
        cscr_host_model_i.wr(12'h041, 8'h30, 8'h33);
        for (int i = 0; i < 2; i++) begin
            txd_in = i[0];
            second_tx_input = !i[0];
            step(2);
            cp(rxd_out, i[0]);
            cp(second_rx_output, !i[0]);
            cp(bus_tx_dominant, 1'b0);
        end
        cscr_host_model_i.wr(12'h041, 8'h00, 8'h33);
        txd_in = 1'b0;
        step(2);
        cp(bus_tx_dominant, 1'b1);
        $display("test loopback done");
        mode_actual = 4'h1;
        mon = 10'h000;
        irq = 3'h1;
        for (int s = 1; s >= 0; s--) begin
            cscr_host_model_i.wr(12'h046, {5'h00, s[0], 2'h0}, 8'h1d);
            step(2);
            cp(rxd_out, !s[0]);
        end
        irq = 3'h4;
        step(2);
        cp(rxd_out, 1'b0);
        $display("test scope done");
        final_report();
    end
endmodule : cscr_regs_tb

/* include/cscr_pkg.sv */
// Package for the system and CAN status and configuration register bank.
// Assumes one 25 MHz clock and a parallel register port from an SPI front end.
package cscr_pkg;

    // ==========================================================
    // Register addresses.
    localparam logic [11:0] ADDR_CAN_CFG  = 12'h041;
    localparam logic [11:0] ADDR_SYS_CFG  = 12'h046;
    localparam logic [11:0] ADDR_SYS_STAT = 12'h071;
    localparam logic [11:0] ADDR_CAN_STAT = 12'h072;

    // ==========================================================
    // Writable field masks and reset values.
    localparam logic [7:0] CAN_CFG_MASK  = 8'h33;
    localparam logic [7:0] SYS_CFG_MASK  = 8'h1d;
    localparam logic [7:0] CFG_DEFAULT   = 8'h00;

    // ==========================================================
    // Bit positions.
    localparam int SYS_OT_BIT      = 5;
    localparam int SYS_SDM_BIT     = 4;
    localparam int SYS_UV_BIT      = 3;
    localparam int SYS_NMS_BIT     = 2;
    localparam int SYS_DIRECT_NORMAL_ENTRY_FLAG_BIT    = 1;
    localparam int SYS_WAKE_BIT    = 0;
    localparam int SCFG_SLEEPDIS   = 4;
    localparam int SCFG_CLAMPDIS   = 3;
    localparam int SCFG_IRQ_SCOPE  = 2;
    localparam int SCFG_SHARED     = 0;
    localparam int CCFG_LP1        = 5;
    localparam int CCFG_LP2        = 4;
    localparam int CCFG_LPL        = 1;
    localparam int CCFG_WAKE       = 0;
    localparam int CST_READY       = 7;
    localparam int CST_SILENCE     = 3;
    localparam int CST_BUSDOM      = 2;
    localparam int CST_TX2DOM      = 1;
    localparam int CST_TX1DOM      = 0;

    // ==========================================================
    // Timing.
    localparam int CLK_MHZ         = 25;
    localparam int SILENCE_TO_US   = 1000;

    // ==========================================================
    // Mode codes.
    typedef enum logic [3:0] {
        MODE_SLEEP   = 4'b0001,
        MODE_STANDBY = 4'b0110,
        MODE_LISTEN  = 4'b1000,
        MODE_NORMAL  = 4'b1111
    } cscr_mode_t;

    // Monitored conditions from the analog and mode logic.
    typedef struct packed {
        logic overtemp;
        logic supply_uv;
        logic dev_mode;
        logic wake_pin;
        logic in_reset_mode;
        logic can_active;
        logic tx_ready;
        logic bus_stuck;
        logic tx2_stuck;
        logic tx1_stuck;
    } cscr_mon_t;

    // Pending interrupt sources.
    typedef struct packed {
        logic wake;
        logic power_on;
        logic any_enabled;
    } cscr_irq_t;

    // Configuration handed to the rest of the device.
    typedef struct packed {
        logic sleep_disable;
        logic clamp_disable;
        logic shared_supply_select;
        logic low_power_listen_en;
        logic wake_pattern_select;
    } cscr_cfg_t;

endpackage : cscr_pkg

/* verilog/cscr_regs.sv */
// System and CAN status and configuration register bank.
// Assumes an SPI front end issues one-cycle read and write strobes with
// a 12-bit address; all inputs are synchronous to ref_clk.
// How it works
// - Overtemp bit needs Normal requested and Normal or listen actual.
// - Supply undervoltage bit follows the detector level.
// - Normal entry bit is 0 once Normal reached after power-up, else 1.
// - Direct entry bit sets if Normal is first reached from Reset, clear without Normal.
// - Scope bit picks wake/power-on or all enabled interrupts on RX line.
// - Supply bit selects separate or common supplies for biasing.
// - Configuration fields return to zero when startup completes.
// - Primary loopback sends transmit to receive, bus recessive, when active.
// - Second loopback likewise, only when pins form the second pair.
// - Low-power listen bit enables the low-power listen variant.
// - Wake pattern bit picks three-phase or four-phase pattern.
// - Ready bit reads 1 only when active and ready to transmit.
// - Silence bit sets after the bus is silent past the timeout.
// - Bus stuck bit follows bus clamped dominant detection.
// - Second transmit stuck bit follows its clamp detection.
// - Primary transmit stuck bit follows its clamp detection.
// - Mode fields use codes 0001, 0110, 1000 and 1111.
`timescale 1ns/1ps
module cscr_regs #(
    parameter int SILENCE_CYCLES = cscr_pkg::SILENCE_TO_US * cscr_pkg::CLK_MHZ
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              startup_done,
    input  wire logic [11:0]       reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic [3:0]        mode_request,
    input  wire logic [3:0]        mode_actual,
    input  wire cscr_pkg::cscr_mon_t mon,
    input  wire cscr_pkg::cscr_irq_t irq,
    input  wire logic              second_pair_cfg,
    input  wire logic              txd_in,
    input  wire logic              second_tx_input,
    input  wire logic              bus_rx_dominant,
    output logic                   bus_tx_dominant,
    output logic                   rxd_out,
    output logic                   second_rx_output,
    output cscr_pkg::cscr_cfg_t    cfg
);

    initial begin
        if (SILENCE_CYCLES < 1) begin
            $error("SILENCE_CYCLES must be at least one.");
        end
    end

    // ==========================================================
    // Helpers.
    function automatic logic is_mode(input logic [3:0] m,
                                     input cscr_pkg::cscr_mode_t c);
        is_mode = (m == c);
    endfunction : is_mode

    // ==========================================================
    // Configuration registers.
    logic [7:0] can_cfg_q;
    logic [7:0] can_cfg_d;
    logic [7:0] sys_cfg_q;
    logic [7:0] sys_cfg_d;

    always_comb begin
        can_cfg_d = can_cfg_q;
        sys_cfg_d = sys_cfg_q;
        if (startup_done) begin
            can_cfg_d = cscr_pkg::CFG_DEFAULT;
            sys_cfg_d = cscr_pkg::CFG_DEFAULT;
        end else if (reg_wr) begin
            if (reg_addr == cscr_pkg::ADDR_CAN_CFG) begin
                can_cfg_d = reg_wdata & cscr_pkg::CAN_CFG_MASK;
            end
            if (reg_addr == cscr_pkg::ADDR_SYS_CFG) begin
                sys_cfg_d = reg_wdata & cscr_pkg::SYS_CFG_MASK;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            can_cfg_q <= cscr_pkg::CFG_DEFAULT;
            sys_cfg_q <= cscr_pkg::CFG_DEFAULT;
        end else begin
            can_cfg_q <= can_cfg_d;
            sys_cfg_q <= sys_cfg_d;
        end
    end

    always_comb begin
        cfg.sleep_disable        = sys_cfg_q[cscr_pkg::SCFG_SLEEPDIS];
        cfg.clamp_disable        = sys_cfg_q[cscr_pkg::SCFG_CLAMPDIS];
        cfg.shared_supply_select = sys_cfg_q[cscr_pkg::SCFG_SHARED];
        cfg.low_power_listen_en  = can_cfg_q[cscr_pkg::CCFG_LPL];
        cfg.wake_pattern_select  = can_cfg_q[cscr_pkg::CCFG_WAKE];
    end

    // ==========================================================
    // Normal entry history.
    logic normal_seen_q;
    logic normal_seen_d;
    logic direct_q;
    logic direct_d;
    logic in_reset_q;
    logic in_reset_d;

    always_comb begin
        normal_seen_d = normal_seen_q;
        direct_d      = direct_q;
        in_reset_d    = mon.in_reset_mode;
        if (is_mode(mode_actual, cscr_pkg::MODE_NORMAL)) begin
            normal_seen_d = 1'b1;
            if (in_reset_q && !normal_seen_q) begin
                direct_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            normal_seen_q <= 1'b0;
            direct_q      <= 1'b0;
            in_reset_q    <= 1'b0;
        end else begin
            normal_seen_q <= normal_seen_d;
            direct_q      <= direct_d;
            in_reset_q    <= in_reset_d;
        end
    end

    // ==========================================================
    // Bus silence.
    logic silent;

    cscr_silence_timer #(
        .CYCLES (SILENCE_CYCLES)
    ) u_silence (
        .clk          (ref_clk),
        .rst_n        (rst_n),
        .bus_dominant (bus_rx_dominant),
        .silent       (silent)
    );

    // ==========================================================
    // Live status words.
    logic [7:0] sys_stat;
    logic [7:0] can_stat;
    logic       ot_ok;

    always_comb begin
        ot_ok = is_mode(mode_request, cscr_pkg::MODE_NORMAL)
             && (is_mode(mode_actual, cscr_pkg::MODE_NORMAL)
              || is_mode(mode_actual, cscr_pkg::MODE_LISTEN));
        sys_stat = 8'h00;
        sys_stat[cscr_pkg::SYS_OT_BIT]   = ot_ok && mon.overtemp;
        sys_stat[cscr_pkg::SYS_SDM_BIT]  = mon.dev_mode;
        sys_stat[cscr_pkg::SYS_UV_BIT]   = mon.supply_uv;
        sys_stat[cscr_pkg::SYS_NMS_BIT]  = !normal_seen_q;
        sys_stat[cscr_pkg::SYS_DIRECT_NORMAL_ENTRY_FLAG_BIT] = direct_q;
        sys_stat[cscr_pkg::SYS_WAKE_BIT] = mon.wake_pin;
        can_stat = 8'h00;
        can_stat[cscr_pkg::CST_READY]   = mon.can_active
                                       && mon.tx_ready;
        can_stat[cscr_pkg::CST_SILENCE] = silent;
        can_stat[cscr_pkg::CST_BUSDOM]  = mon.bus_stuck;
        can_stat[cscr_pkg::CST_TX2DOM]  = mon.tx2_stuck;
        can_stat[cscr_pkg::CST_TX1DOM]  = mon.tx1_stuck;
    end

    // ==========================================================
    // Read port. Status addresses have no write path.
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                cscr_pkg::ADDR_CAN_CFG:  rdata_d = can_cfg_q;
                cscr_pkg::ADDR_SYS_CFG:  rdata_d = sys_cfg_q;
                cscr_pkg::ADDR_SYS_STAT: rdata_d = sys_stat;
                cscr_pkg::ADDR_CAN_STAT: rdata_d = can_stat;
                default:                 rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ==========================================================
    // Receive, transmit and loopback paths.
    logic bus_tx_q;
    logic bus_tx_d;
    logic rxd_q;
    logic rxd_d;
    logic rx2_q;
    logic rx2_d;
    logic lp1;
    logic lp2;
    logic low_pwr;
    logic irq_line;

    always_comb begin
        lp1 = mon.can_active && can_cfg_q[cscr_pkg::CCFG_LP1];
        lp2 = mon.can_active && second_pair_cfg
           && can_cfg_q[cscr_pkg::CCFG_LP2];
        low_pwr = is_mode(mode_actual, cscr_pkg::MODE_SLEEP)
               || is_mode(mode_actual, cscr_pkg::MODE_STANDBY);
        if (sys_cfg_q[cscr_pkg::SCFG_IRQ_SCOPE]) begin
            irq_line = irq.any_enabled;
        end else begin
            irq_line = irq.wake || irq.power_on;
        end
        bus_tx_d = 1'b0;
        if (mon.can_active && !lp1 && !lp2) begin
            bus_tx_d = !txd_in;
        end
        if (low_pwr) begin
            rxd_d = !irq_line;
        end else if (lp1) begin
            rxd_d = txd_in;
        end else begin
            rxd_d = !bus_rx_dominant;
        end
        if (lp2) begin
            rx2_d = second_tx_input;
        end else begin
            rx2_d = !bus_rx_dominant;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_tx_q <= 1'b0;
            rxd_q    <= 1'b1;
            rx2_q    <= 1'b1;
        end else begin
            bus_tx_q <= bus_tx_d;
            rxd_q    <= rxd_d;
            rx2_q    <= rx2_d;
        end
    end

    assign bus_tx_dominant  = bus_tx_q;
    assign rxd_out          = rxd_q;
    assign second_rx_output = rx2_q;

endmodule : cscr_regs

/* verilog/cscr_silence_timer.sv */
// Bus silence timer: flags a recessive bus that lasts past a timeout.
// Assumes bus_dominant is synchronous to clk.
`timescale 1ns/1ps
module cscr_silence_timer #(
    parameter int CYCLES = 25000
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic bus_dominant,
    output logic      silent
);

    localparam int CW = $clog2(CYCLES + 1);

    initial begin
        if (CYCLES < 1) begin
            $error("CYCLES must be at least one.");
        end
    end

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          silent_q;
    logic          silent_d;

    // ==========================================================
    // Counting.
    always_comb begin
        cnt_d    = cnt_q;
        silent_d = silent_q;
        if (bus_dominant) begin
            cnt_d    = '0;
            silent_d = 1'b0;
        end else if (cnt_q == CW'(CYCLES)) begin
            silent_d = 1'b1;
        end else begin
            cnt_d = cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q    <= '0;
            silent_q <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            silent_q <= silent_d;
        end
    end

    assign silent = silent_q;

endmodule : cscr_silence_timer
